// File: src/fcsi_pkg.sv
// Package with register map, field layout, reset values and timing constants.
package fcsi_pkg;

   // Register byte addresses on the APB word map.
   localparam logic [7:0] ADDR_CLKDIV   = 8'h00;  // Clock divider control.
   localparam logic [7:0] ADDR_SECURITY = 8'h04;  // Lockout state, read only.
   localparam logic [7:0] ADDR_PINDEX   = 8'h08;  // Command parameter index.

   // Field positions and widths inside the divider and index registers.
   localparam int LOADED_BIT = 7;  // Loaded flag position.
   localparam int LOCK_BIT   = 6;  // Lock bit position.
   localparam int DIV_W      = 6;  // Width of the divider value.
   localparam int PIDX_W     = 3;  // Width of the parameter index field.

   // Reset values.
   localparam logic [7:0] CLKDIV_RESET = 8'h00;  // Divider register after reset.
   localparam logic [2:0] PIDX_RESET   = 3'h0;   // Parameter index after reset.
   localparam logic [7:0] SEC_ALL_ONES = 8'hff;  // Security value on a double fault.

   // Two-bit codes of the security byte.
   localparam logic [1:0] KEY_ENABLED  = 2'h2;  // Only code that opens the backdoor.
   localparam logic [1:0] SEC_UNLOCKED = 2'h2;  // Only code that means unlocked.

   // Time base: nominal period of the divided tick.
   localparam int TICK_NS     = 1000;  // Nominal 1 MHz tick period in ns.
   localparam int CLK_NS      = 10;    // Bus clock period in ns.
   localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;  // Cycles per tick at 100 MHz.

   // APB request group carried as one struct.
   typedef struct packed {
      logic        psel;     // Slave select.
      logic        penable;  // Access phase.
      logic        pwrite;   // Write direction.
      logic [7:0]  paddr;    // Byte address.
      logic [31:0] pwdata;   // Write data.
   } apb_req_t;

   // APB answer group carried as one struct.
   typedef struct packed {
      logic        pready;   // Transfer done.
      logic        pslverr;  // Unmapped address.
      logic [31:0] prdata;   // Read data.
   } apb_rsp_t;

   // Decoded security outputs.
   typedef struct packed {
      logic backdoor_enabled;  // Backdoor key access allowed.
      logic unlocked;          // Device unlocked.
   } sec_status_t;

endpackage

// File: src/flash_clock_security_index_regs.sv
// Divider, security and parameter index registers behind an APB slave.
// Behaviour
// [R1] Bit 7 reads loaded after first write
// [R2] Writes to bit 7 always ignored
// [R3] Normal mode: lock set once, freezes divider
// [R4] Special mode: bits 6-0 always writable
// [R5] Divider value makes nominal 1 MHz tick
// [R6] Software avoids divider writes during commands
// [R7] Software picks divider by clock band
// [R8] Security register readable, never writable
// [R9] Security byte loaded during reset sequence
// [R10] Double fault sets all security bits
// [R11] Backdoor enabled only by code 10
// [R12] Unlocked only by code 10
// [R13] Backdoor unlock forces lockout to 10
// [R14] Software keeps reserved bits erased
// [R15] Index field read/write, rest zero
// [R16] Index tells count of parameter words
// [R17] Loaded flag set on write until reset
// [R18] Index field three bits, resets to zero
`timescale 1ns/1ps
module flash_clock_security_index_regs
   import fcsi_pkg::*;
(
   input  wire logic               core_clk,          // Bus clock, 100 MHz.
   input  wire logic               rst,               // Synchronous reset, active high.
   input  wire logic               psel,              // APB select.
   input  wire logic               penable,           // APB access phase.
   input  wire logic               pwrite,            // APB write.
   input  wire logic [7:0]         paddr,             // APB byte address.
   input  wire logic [31:0]        pwdata,            // APB write data.
   output logic                    pready,            // APB ready.
   output logic                    pslverr,           // APB error on unmapped address.
   output logic      [31:0]        prdata,            // APB read data.
   input  wire logic               special_mode,      // Special mode strap level.
   input  wire logic               command_complete_flag, // Low while a command runs.
   input  wire logic               sec_load_strobe,   // Reset sequence security fetch.
   input  wire logic [7:0]         nv_sec_byte,       // Security byte from flash.
   input  wire logic               nv_double_fault,   // Double fault on that fetch.
   input  wire logic               backdoor_unlock,   // Successful backdoor key pulse.
   output logic      [DIV_W-1:0]   divider_value,     // Divider value in use.
   output logic                    divider_loaded_flag, // Divider written since reset.
   output logic                    divider_lock_bit,  // Divider locked.
   output logic                    time_tick,         // Nominal 1 MHz tick pulse.
   output logic      [PIDX_W-1:0]  param_index_field, // Parameter words index.
   output logic                    backdoor_gate,     // Backdoor key access enabled.
   output logic                    device_unlocked,   // Lockout field says unlocked.
   output logic                    div_write_in_cmd   // Divider write seen mid-command.
);

   // All register state in one struct.
   typedef struct packed {
      logic              loaded;   // Loaded flag.
      logic              lock;     // Lock bit.
      logic [DIV_W-1:0]  div;      // Divider value.
      logic [PIDX_W-1:0] pidx;     // Parameter index.
      logic [31:0]       rdata;    // Registered read data.
      logic              slverr;   // Registered error answer.
      logic              ready;    // Access answered.
      logic              misuse;   // Sticky divider write during command.
   } regs_state_t;

   regs_state_t state_q;  // Registered state.
   regs_state_t state_d;  // Next state.

   logic [7:0]   sec_value;   // Security register contents.
   sec_status_t  sec_status;  // Decoded security fields.
   logic         acc;         // First access-phase cycle seen, answer next cycle.
   logic         wr_acc;      // Write accepted this cycle.
   logic         hit_div;     // Divider address.
   logic         hit_sec;     // Security address.
   logic         hit_idx;     // Index address.
   logic [7:0]   div_rd;      // Divider register as read.

   // Address decode for the three registers.
   assign hit_div = (paddr == ADDR_CLKDIV);
   assign hit_sec = (paddr == ADDR_SECURITY);
   assign hit_idx = (paddr == ADDR_PINDEX);

   // An access is registered in the first access-phase cycle and answered in the second.
   assign acc    = psel && penable && !state_q.ready;
   assign wr_acc = acc && pwrite;

   // Divider register as seen by software.
   assign div_rd = {state_q.loaded, state_q.lock, state_q.div};

   // Next-state logic for registers and bus answer.
   always_comb begin
      state_d        = state_q;
      state_d.ready  = acc;
      if (acc) begin
         // Read data and error settle together with ready.
         state_d.slverr = !(hit_div || hit_sec || hit_idx);
         state_d.rdata  = 32'h0000_0000;
         if (hit_div) begin
            state_d.rdata[7:0] = div_rd;
         end else if (hit_sec) begin
            // [R8] Security read only
            state_d.rdata[7:0] = sec_value;
         end else if (hit_idx) begin
            // [R15] Index reads, rest zero
            state_d.rdata[PIDX_W-1:0] = state_q.pidx;
         end
      end
      if (wr_acc && hit_div) begin
         // [R4] Special mode bypasses lock
         if (special_mode) begin
            state_d.lock = pwdata[LOCK_BIT];
            state_d.div  = pwdata[DIV_W-1:0];
            // [R17] Loaded on accepted write
            state_d.loaded = 1'b1;
         end else if (!state_q.lock) begin
            // [R3] Lock set once, divider open
            state_d.lock = pwdata[LOCK_BIT];
            state_d.div  = pwdata[DIV_W-1:0];
            state_d.loaded = 1'b1;
         end
         // [R2] Bit 7 never from the bus
         // Flag a divider write made while a command is executing.
         if (!command_complete_flag) begin
            state_d.misuse = 1'b1;
         end
      end
      if (wr_acc && hit_idx) begin
         // [R16] Software sets parameter count
         state_d.pidx = pwdata[PIDX_W-1:0];
      end
   end

   // Register all state; control bits take defined values in reset.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         // [R18] Index resets to zero
         state_q <= '{loaded: CLKDIV_RESET[LOADED_BIT], lock: CLKDIV_RESET[LOCK_BIT],
                      div: CLKDIV_RESET[DIV_W-1:0], pidx: PIDX_RESET,
                      rdata: 32'h0000_0000, slverr: 1'b0, ready: 1'b0, misuse: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   // Bus answer: ready is combinational so wait stays one cycle.
   assign pready  = psel && penable && state_q.ready;
   assign pslverr = pready && state_q.slverr;
   assign prdata  = state_q.rdata;

   // Register outputs toward the flash controller.
   assign divider_value       = state_q.div;
   // [R1] Loaded flag reported
   assign divider_loaded_flag = state_q.loaded;
   assign divider_lock_bit    = state_q.lock;
   assign param_index_field   = state_q.pidx;
   assign backdoor_gate       = sec_status.backdoor_enabled;
   assign device_unlocked     = sec_status.unlocked;
   // [R6] Misuse made visible
   assign div_write_in_cmd    = state_q.misuse;

   // Security register with load and decode.
   sec_byte_loader i_sec_byte_loader (
      .core_clk        (core_clk),
      .rst             (rst),
      .load_strobe     (sec_load_strobe),
      .nv_sec_byte     (nv_sec_byte),
      .nv_double_fault (nv_double_fault),
      .backdoor_unlock (backdoor_unlock),
      .sec_value       (sec_value),
      .sec_status      (sec_status)
   );

   // Time base runs once the divider has been loaded.
   tick_divider #(
      .W (DIV_W)
   ) i_tick_divider (
      .core_clk  (core_clk),
      .rst       (rst),
      .run       (state_q.loaded),
      .div_value (state_q.div),
      .tick      (time_tick)
   );

   // Loaded flag set after an accepted divider write.
   a_loaded_set: assert property (@(posedge core_clk) disable iff (rst)  // [R17]
      wr_acc && hit_div && (special_mode || !divider_lock_bit) |=> divider_loaded_flag)
      else $error("loaded flag not set by write");
   // Loaded flag never falls outside reset.
   a_loaded_sticky: assert property (@(posedge core_clk) disable iff (rst)  // [R1]
      divider_loaded_flag |=> divider_loaded_flag)
      else $error("loaded flag fell");
   // Read of divider shows bit 7 from the flag, never from write data.
   a_bit7_readback: assert property (@(posedge core_clk) disable iff (rst)  // [R2]
      pready && !pwrite && hit_div |-> prdata[7] == $past(divider_loaded_flag))
      else $error("bit 7 readback wrong");
   // Locked divider holds in normal mode.
   a_lock_holds: assert property (@(posedge core_clk) disable iff (rst)  // [R3]
      divider_lock_bit && !special_mode |=> $stable(divider_value) && divider_lock_bit)
      else $error("locked divider changed");
   // Special mode write lands regardless of lock.
   a_special_write: assert property (@(posedge core_clk) disable iff (rst)  // [R4]
      wr_acc && hit_div && special_mode |=> divider_value == $past(pwdata[5:0]))
      else $error("special mode write lost");
   // Index write lands in the three-bit field.
   a_index_write: assert property (@(posedge core_clk) disable iff (rst)  // [R15]
      wr_acc && hit_idx |=> param_index_field == $past(pwdata[2:0]))
      else $error("index write lost");
   // Security read returns the register value.
   a_sec_read: assert property (@(posedge core_clk) disable iff (rst)  // [R8]
      pready && !pwrite && hit_sec |-> prdata == {24'h000000, $past(sec_value)})
      else $error("security read wrong");
   // Every access is answered one cycle into the access phase.
   a_apb_answer: assert property (@(posedge core_clk) disable iff (rst)
      psel && penable && !pready |=> pready)
      else $error("apb answer late");

   c_lock_write: cover property (@(posedge core_clk) wr_acc && hit_div && pwdata[6]);
   c_special_relock: cover property (@(posedge core_clk)
      wr_acc && hit_div && special_mode && divider_lock_bit);
   c_tick: cover property (@(posedge core_clk) time_tick);

endmodule

// File: src/sec_byte_loader.sv
// Security register loaded on the reset sequence fetch strobe, with decode of its fields.
`timescale 1ns/1ps
module sec_byte_loader
   import fcsi_pkg::*;
(
   input  wire logic        core_clk,          // Bus clock.
   input  wire logic        rst,               // Synchronous reset, active high.
   input  wire logic        load_strobe,       // Reset sequence fetch of the byte.
   input  wire logic [7:0]  nv_sec_byte,       // Security byte read from flash.
   input  wire logic        nv_double_fault,   // Double-bit fault on that read.
   input  wire logic        backdoor_unlock,   // Successful backdoor key pulse.
   output logic      [7:0]  sec_value,         // Register contents.
   output sec_status_t      sec_status         // Decoded fields.
);

   // All state in one struct.
   typedef struct packed {
      logic [7:0] sec;  // Security register.
   } sec_state_t;

   sec_state_t state_q;  // Registered state.
   sec_state_t state_d;  // Next state.

   // Next-state logic for the security register.
   always_comb begin
      state_d = state_q;
      if (load_strobe) begin
         // [R10] Double fault locks
         if (nv_double_fault) begin
            state_d.sec = SEC_ALL_ONES;
         end else begin
            // [R9] Load nonvolatile byte
            state_d.sec = nv_sec_byte;
         end
      end else if (backdoor_unlock) begin
         // [R13] Force unlocked code
         state_d.sec[1:0] = SEC_UNLOCKED;
      end
   end

   // Register the state; reset value is fully locked until loaded.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= '{sec: SEC_ALL_ONES};
      end else begin
         state_q <= state_d;
      end
   end

   // Output the value and decoded fields.
   assign sec_value = state_q.sec;
   // [R11] Backdoor gate decode
   assign sec_status.backdoor_enabled = (state_q.sec[7:6] == KEY_ENABLED);
   // [R12] Lockout field decode
   assign sec_status.unlocked = (state_q.sec[1:0] == SEC_UNLOCKED);

   // Loading on a fault always leaves every bit set.
   a_fault_all_ones: assert property (@(posedge core_clk) disable iff (rst)  // [R10]
      load_strobe && nv_double_fault |=> sec_value == SEC_ALL_ONES)
      else $error("security byte not all ones after fault");
   // A clean load copies the byte.
   a_clean_load_copy: assert property (@(posedge core_clk) disable iff (rst)  // [R9]
      load_strobe && !nv_double_fault |=> sec_value == $past(nv_sec_byte))
      else $error("security byte not loaded");
   // Backdoor unlock yields unlocked state.
   a_unlock_forces: assert property (@(posedge core_clk) disable iff (rst)  // [R13]
      backdoor_unlock && !load_strobe |=> sec_status.unlocked)
      else $error("unlock did not force code");
   // Backdoor enabled exactly for code 10.
   a_key_decode: assert property (@(posedge core_clk) disable iff (rst)  // [R11]
      sec_status.backdoor_enabled == (sec_value[7:6] == 2'h2))
      else $error("backdoor decode wrong");
   // Unlocked exactly for code 10.
   a_lock_decode: assert property (@(posedge core_clk) disable iff (rst)  // [R12]
      sec_status.unlocked == (sec_value[1:0] == 2'h2))
      else $error("lockout decode wrong");
   // Value only changes by load or unlock.
   a_sec_stable: assert property (@(posedge core_clk) disable iff (rst)  // [R8]
      !load_strobe && !backdoor_unlock |=> $stable(sec_value))
      else $error("security register changed without cause");

   c_fault_load: cover property (@(posedge core_clk) load_strobe && nv_double_fault);
   c_unlock: cover property (@(posedge core_clk) backdoor_unlock);

endmodule

// File: src/tick_divider.sv
// Divider that turns the bus clock into a nominal 1 MHz tick.
`timescale 1ns/1ps
module tick_divider
   import fcsi_pkg::*;
#(
   parameter int W = DIV_W  // Width of the divider value.
) (
   input  wire logic         core_clk,   // Bus clock.
   input  wire logic         rst,        // Synchronous reset, active high.
   input  wire logic         run,        // Divider loaded and counting.
   input  wire logic [W-1:0] div_value,  // Bus cycles per tick minus one.
   output logic              tick        // One-cycle pulse per period.
);

   // All state in one struct.
   typedef struct packed {
      logic [W-1:0] cnt;  // Down counter.
      logic         tick; // Registered tick.
   } div_state_t;

   div_state_t state_q;  // Registered state.
   div_state_t state_d;  // Next state.

   // Count div_value+1 bus cycles per tick.
   always_comb begin
      state_d      = state_q;
      state_d.tick = 1'b0;
      if (!run) begin
         state_d.cnt = div_value;
      end else if (state_q.cnt == '0) begin
         // [R5] Tick every value+1 cycles
         state_d.cnt  = div_value;
         state_d.tick = 1'b1;
      end else begin
         state_d.cnt = state_q.cnt - 1'b1;
      end
   end

   // Register the state.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign tick = state_q.tick;

   // A tick is never issued while stopped.
   a_no_tick_idle: assert property (@(posedge core_clk) disable iff (rst)  // [R5]
      !run ##1 !run |=> !tick)
      else $error("tick while divider stopped");

endmodule

// File: test/flash_clock_security_index_regs_test.sv
// Self-checking testbench for the divider, security and parameter index registers.
`timescale 1ns/1ps
module flash_clock_security_index_regs_test
   import fcsi_pkg::*;
;
   logic                core_clk;               // Bus clock.
   logic                rst;                    // Synchronous reset.
   logic                psel;                   // APB select.
   logic                penable;                // APB access phase.
   logic                pwrite;                 // APB direction.
   logic [7:0]          paddr;                  // APB address.
   logic [31:0]         pwdata;                 // APB write data.
   logic                pready;                 // APB ready.
   logic                pslverr;                // APB error.
   logic [31:0]         prdata;                 // APB read data.
   logic                special_mode;           // Mode strap.
   logic                command_complete_flag;  // Low while a command runs.
   logic                sec_load_strobe;        // Security fetch pulse.
   logic [7:0]          nv_sec_byte;            // Security byte from flash.
   logic                nv_double_fault;        // Double fault on the fetch.
   logic                backdoor_unlock;        // Backdoor unlock pulse.
   logic [DIV_W-1:0]    divider_value;          // Divider in use.
   logic                divider_loaded_flag;    // Divider written.
   logic                divider_lock_bit;       // Divider locked.
   logic                time_tick;              // Divided tick.
   logic [PIDX_W-1:0]   param_index_field;      // Parameter index.
   logic                backdoor_gate;          // Backdoor allowed.
   logic                device_unlocked;        // Device unlocked.
   logic                div_write_in_cmd;       // Divider write seen mid-command.
   int                  n_mismatch;             // Mismatches seen.
   int                  comparisons;            // Comparisons made.
   logic [7:0]          div_m;                  // Expected divider register.
   logic [7:0]          sec_m;                  // Expected security register.
   logic [2:0]          idx_m;                  // Expected index field.
   logic [31:0]         rdv;                    // Scratch read data.
   logic                erv;                    // Scratch error flag.

   flash_clock_security_index_regs i_flash_clock_security_index_regs (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .special_mode(special_mode), .command_complete_flag(command_complete_flag),
      .sec_load_strobe(sec_load_strobe), .nv_sec_byte(nv_sec_byte),
      .nv_double_fault(nv_double_fault), .backdoor_unlock(backdoor_unlock),
      .divider_value(divider_value), .divider_loaded_flag(divider_loaded_flag),
      .divider_lock_bit(divider_lock_bit), .time_tick(time_tick),
      .param_index_field(param_index_field), .backdoor_gate(backdoor_gate),
      .device_unlocked(device_unlocked), .div_write_in_cmd(div_write_in_cmd));

   // Free-running bus clock at 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One APB transfer; ready is looked at just before the edge that samples it.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20) begin
         n_mismatch++;
         $display("[FAIL] %0t no ready answer", $time);
      end
      rd  = prdata;
      err = pslverr;
      @(posedge core_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write without looking at the answer beyond the handshake.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   // Read and compare with the expected byte; error must stay low.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, {24'h0, exp}, msg);
      check(32'(e), 32'h0, "error on mapped read");
   endtask

   // Expected divider after a write: accepted when unlocked or in special mode.
   function automatic logic [7:0] div_next(input logic [7:0] cur, input logic [7:0] d,
                                           input logic spec);
      if (spec || !cur[LOCK_BIT]) begin
         return {1'b1, d[6:0]};
      end
      return cur;
   endfunction

   // Compares the divider, index and security ports with the expected register images.
   task automatic check_ports();
      @(negedge core_clk);
      check(32'(divider_value), 32'(div_m[5:0]), "divider port");
      check(32'(divider_lock_bit), 32'(div_m[6]), "lock port");
      check(32'(divider_loaded_flag), 32'(div_m[7]), "loaded port");
      check(32'(param_index_field), 32'(idx_m), "index port");
      check(32'(backdoor_gate), 32'(sec_m[7:6] == KEY_ENABLED), "gate port");
      check(32'(device_unlocked), 32'(sec_m[1:0] == SEC_UNLOCKED), "unlock port");
   endtask

   // Holds reset for the given number of cycles and resets the images.
   task automatic do_reset(input int cycles);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (cycles) @(posedge core_clk);
      rst   <= 1'b0;
      div_m = CLKDIV_RESET;
      sec_m = SEC_ALL_ONES;
      idx_m = PIDX_RESET;
   endtask

   // Presents a security byte with the fetch pulse for one edge.
   task automatic sec_load(input logic [7:0] b, input logic df);
      @(posedge core_clk);
      sec_load_strobe <= 1'b1;
      nv_sec_byte     <= b;
      nv_double_fault <= df;
      @(posedge core_clk);
      sec_load_strobe <= 1'b0;
      sec_m = df ? SEC_ALL_ONES : b;
   endtask

   // Writes the divider and checks register, ports and loaded flag.
   task automatic div_wr(input logic [7:0] d);
      wr(ADDR_CLKDIV, {24'h0, d});
      div_m = div_next(div_m, d, special_mode);
      rd_chk(ADDR_CLKDIV, div_m, "divider readback");
      check_ports();
   endtask

   // Spacing between two ticks must be the divider plus one.
   task automatic tick_chk();
      int n;
      n = 0;
      while (time_tick !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (time_tick !== 1'b1 && n < 200);
      check(32'(n), 32'(div_m[5:0]) + 32'h1, "tick spacing");
   endtask

   // Watchdog cuts a hang short.
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end

   // Main sequence.
   initial begin
      logic [7:0]  b;
      logic [31:0] w;
      n_mismatch = 0;
      comparisons = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      special_mode = 1'b0;
      command_complete_flag = 1'b1;
      sec_load_strobe = 1'b0;
      nv_sec_byte = 8'h00;
      nv_double_fault = 1'b0;
      backdoor_unlock = 1'b0;
      void'($urandom(32'he75d));
      do_reset(20);
      rd_chk(ADDR_CLKDIV, 8'h00, "divider reset");
      rd_chk(ADDR_PINDEX, 8'h00, "index reset");
      check_ports();
      // Unmapped place answers with an error and zero data.
      apb(1'b1, 8'h0c, 32'hffffffff, rdv, erv);
      apb(1'b0, 8'h0c, 32'h0, rdv, erv);
      check(rdv, 32'h0, "unmapped data");
      check(32'(erv), 32'h1, "unmapped error");
      for (int i = 0; i < 5; i++) begin
         w = (i == 0) ? 32'hffffffff : $urandom();
         wr(ADDR_PINDEX, w);
         idx_m = w[2:0];
         rd_chk(ADDR_PINDEX, {5'h0, idx_m}, "index readback");
         check_ports();
      end
      // Every key and lockout code, with writes that must not land.
      for (int i = 0; i < 16; i++) begin
         b = {i[3:2], 4'($urandom()), i[1:0]};
         sec_load(b, 1'b0);
         check_ports();
         wr(ADDR_SECURITY, {24'h0, ~b});
         rd_chk(ADDR_SECURITY, sec_m, "security readback");
      end
      sec_load(8'h81, 1'b1);
      rd_chk(ADDR_SECURITY, 8'hff, "double fault");
      sec_load(8'h7c, 1'b0);
      @(posedge core_clk);
      backdoor_unlock <= 1'b1;
      @(posedge core_clk);
      backdoor_unlock <= 1'b0;
      sec_m[1:0] = 2'b10;
      check_ports();
      rd_chk(ADDR_SECURITY, sec_m, "unlock forced");
      // Normal mode: writable until locked, frozen after.
      div_wr({2'b00, 6'($urandom())});
      div_wr({2'b00, 6'($urandom())});
      div_wr({2'b01, 2'b00, 4'($urandom())});
      div_wr({2'b00, 6'($urandom())});
      tick_chk();
      // Special mode ignores the lock but not bit 7.
      @(posedge core_clk);
      special_mode <= 1'b1;
      div_wr({2'b01, 6'($urandom())});
      div_wr(8'h00);
      div_wr({2'b01, 6'h00});
      tick_chk();
      @(posedge core_clk);
      special_mode <= 1'b0;
      // Reset in mid-run clears lock and loaded flag.
      do_reset(3);
      check_ports();
      check(32'(div_write_in_cmd), 32'h0, "mid-command flag reset");
      div_wr({2'b00, 6'h31});
      tick_chk();
      // Divider write while a command runs is flagged.
      @(posedge core_clk);
      command_complete_flag <= 1'b0;
      div_wr({2'b00, 6'h05});
      check(32'(div_write_in_cmd), 32'h1, "mid-command write seen");
      command_complete_flag <= 1'b1;
      test_done();
   end
endmodule
